//--- rtl/smdp_pkg.sv
// constants, state type and rule summary for the dual serial port front end
// Function
// - async mode: each emitted bit lasts one ETU, 372 carrier periods by default.
// - sync mode: sample data on clock rise, change outgoing data on clock fall.
// - async reset sequence sends the 64-bit answer-to-reset contents.
// - reset input is held high internally so sync mode works unconnected.
// - no answer-to-reset in sync mode.
// - data line driven only low, released otherwise, in both protocols.
// - up to 16 addressed devices share one 2-wire bus.
// - async bit rate may be raised by agreed divisor, up to 153,600 baud.
// - writes accepted as single byte or page up to 128 bytes, self-timed.
// - sync commands open with start condition and close with stop condition.
// - sync mode: received 8-bit words acknowledged low in ninth clock, except a foreign or busy-time address and bytes past a full page.
package smdp_pkg;
    localparam int ETU_DEFAULT = 372;
    localparam int ETU_W = 9;
    localparam int ATR_BYTES = 8;
    localparam int CHAR_LAST_BIT = 11;
    localparam int PAGE_MAX = 128;
    localparam int CLK_HZ = 50000000;
    localparam int TWR_MS = 5;
    localparam int TWR_CYCLES = TWR_MS * (CLK_HZ / 1000);
    localparam int DEV_ADDR_W = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_WDATA,
        S_WACK,
        S_RDATA,
        S_RACK,
        S_ATR
    } smdp_state_t;
endpackage

//--- rtl/smdp_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module smdp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_r <= '1;
            q <= '1;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

//--- rtl/smdp_port.sv
// serial front end: T=0 answer-to-reset sender and addressed 2-wire slave
`timescale 1ns/100ps
module smdp_port #(
    parameter int TWR_CYCLES = smdp_pkg::TWR_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic ASYNC_MODE,
    input wire logic SCL_CLK,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic RST_IN,
    output logic RST_PULLUP_EN,
    input wire logic [smdp_pkg::DEV_ADDR_W-1:0] DEV_ADDR,
    input wire logic [63:0] ATR_DATA,
    input wire logic [smdp_pkg::ETU_W-1:0] ETU_DIV,
    input wire logic [7:0] TX_DATA,
    output logic TX_REQ,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    output logic RX_ADDR,
    output logic PROG_START,
    output logic WR_BUSY,
    output logic ATR_ACTIVE
);
    localparam int BW = $clog2(TWR_CYCLES + 1);

    logic [3:0] pins_s;
    logic scl_s, sda_s, rst_s, async_s;
    logic scl_d_r, sda_d_r, rst_d_r;
    logic scl_rise, scl_fall, start_c, stop_c, rst_rise, etu_done;

    smdp_pkg::smdp_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt;
    logic oe_r, oe_nxt, ack_on_r, ack_on_nxt, ack_ok_r, ack_ok_nxt;
    logic rw_r, rw_nxt, more_r, more_nxt;
    logic [7:0] page_r, page_nxt, rx_r, rx_nxt;
    logic rxv_r, rxv_nxt, rxa_r, rxa_nxt, txq_r, txq_nxt, prog_r, prog_nxt;
    logic [BW-1:0] busy_r, busy_nxt;
    logic [2:0] byte_r, byte_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [smdp_pkg::ETU_W-1:0] etu_r, etu_nxt;

    smdp_sync2 #(.W(4)) u_sync (
        .clk(CLOCK),
        .rstn(RSTN),
        .d({ASYNC_MODE, RST_IN, SDA_IN, SCL_CLK}),
        .q(pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign rst_s = pins_s[2];
    assign async_s = pins_s[3];

    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s && !async_s;
    assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s && !async_s;
    assign rst_rise = rst_s && !rst_d_r;
    // divisor of zero behaves as one so a bad setting cannot stall the sender
    assign etu_done = scl_rise && ({1'b0, etu_r} + 10'h001 >= {1'b0, ETU_DIV});

    function automatic logic char_bit(input logic [7:0] b, input logic [3:0] i);
        if (i == 4'h0)
            char_bit = 1'b0;
        else if (i <= 4'h8)
            char_bit = b[3'(i - 4'h1)];
        else if (i == 4'h9)
            char_bit = ^b;
        else
            char_bit = 1'b1;
    endfunction

    function automatic logic [7:0] atr_byte(input logic [63:0] d, input logic [2:0] n);
        atr_byte = d[{n, 3'h0} +: 8];
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        ack_on_nxt = ack_on_r;
        ack_ok_nxt = ack_ok_r;
        rw_nxt = rw_r;
        more_nxt = more_r;
        page_nxt = page_r;
        rx_nxt = rx_r;
        rxv_nxt = 1'b0;
        rxa_nxt = rxa_r;
        txq_nxt = 1'b0;
        prog_nxt = 1'b0;
        busy_nxt = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
        byte_nxt = byte_r;
        bit_nxt = bit_r;
        etu_nxt = etu_r;
        if (start_c)
        begin
            state_nxt = smdp_pkg::S_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end
        else if (stop_c)
        begin
            // page gathered during this command goes to the self-timed cycle,
            // even after an over-long page left the slave idle
            if (!rw_r && page_r != 8'h00)
            begin
                prog_nxt = 1'b1;
                busy_nxt = BW'(TWR_CYCLES);
            end
            state_nxt = smdp_pkg::S_IDLE;
            oe_nxt = 1'b0;
            page_nxt = 8'h00;
        end
        else
        begin
            case (state_r)
                smdp_pkg::S_IDLE:
                begin
                    oe_nxt = 1'b0;
                    if (async_s && rst_rise)
                    begin
                        state_nxt = smdp_pkg::S_ATR;
                        byte_nxt = 3'h0;
                        bit_nxt = 4'h0;
                        etu_nxt = '0;
                        oe_nxt = 1'b1;
                    end
                end
                smdp_pkg::S_ADDR, smdp_pkg::S_WDATA:
                begin
                    if (scl_rise)
                    begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == smdp_pkg::BITS_PER_BYTE - 4'h1)
                        begin
                            cnt_nxt = 4'h0;
                            ack_on_nxt = 1'b0;
                            rx_nxt = {sh_r[6:0], sda_s};
                            rxv_nxt = 1'b1;
                            rxa_nxt = (state_r == smdp_pkg::S_ADDR);
                            if (state_r == smdp_pkg::S_ADDR)
                            begin
                                rw_nxt = sda_s;
                                page_nxt = 8'h00;
                                // silent unless our address and not programming
                                if (sh_r[6:3] == DEV_ADDR && busy_r == '0)
                                    state_nxt = smdp_pkg::S_ADDR_ACK;
                                else
                                    state_nxt = smdp_pkg::S_IDLE;
                            end
                            else
                            begin
                                state_nxt = smdp_pkg::S_WACK;
                                ack_ok_nxt = (page_r < 8'(smdp_pkg::PAGE_MAX));
                                if (page_r < 8'(smdp_pkg::PAGE_MAX))
                                    page_nxt = page_r + 8'h01;
                            end
                        end
                    end
                end
                smdp_pkg::S_ADDR_ACK, smdp_pkg::S_WACK:
                begin
                    if (scl_fall && !ack_on_r)
                    begin
                        ack_on_nxt = 1'b1;
                        oe_nxt = (state_r == smdp_pkg::S_ADDR_ACK) || ack_ok_r;
                    end
                    else if (scl_fall)
                    begin
                        if (state_r == smdp_pkg::S_ADDR_ACK && rw_r)
                        begin
                            state_nxt = smdp_pkg::S_RDATA;
                            tx_nxt = {TX_DATA[6:0], 1'b0};
                            oe_nxt = !TX_DATA[7];
                            txq_nxt = 1'b1;
                        end
                        else if (state_r == smdp_pkg::S_WACK && !ack_ok_r)
                        begin
                            state_nxt = smdp_pkg::S_IDLE;
                            oe_nxt = 1'b0;
                        end
                        else
                        begin
                            state_nxt = smdp_pkg::S_WDATA;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                smdp_pkg::S_RDATA:
                begin
                    if (scl_rise)
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == smdp_pkg::BITS_PER_BYTE - 4'h1)
                        begin
                            cnt_nxt = 4'h0;
                            ack_on_nxt = 1'b0;
                            more_nxt = 1'b0;
                            state_nxt = smdp_pkg::S_RACK;
                        end
                    end
                    else if (scl_fall)
                    begin
                        oe_nxt = !tx_r[7];
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                end
                smdp_pkg::S_RACK:
                begin
                    if (scl_fall && !ack_on_r)
                    begin
                        ack_on_nxt = 1'b1;
                        oe_nxt = 1'b0;
                    end
                    else if (scl_rise && ack_on_r)
                        more_nxt = !sda_s;
                    else if (scl_fall && more_r)
                    begin
                        state_nxt = smdp_pkg::S_RDATA;
                        tx_nxt = {TX_DATA[6:0], 1'b0};
                        oe_nxt = !TX_DATA[7];
                        txq_nxt = 1'b1;
                    end
                    else if (scl_fall)
                        state_nxt = smdp_pkg::S_IDLE;
                end
                smdp_pkg::S_ATR:
                begin
                    if (!rst_s || !async_s)
                    begin
                        state_nxt = smdp_pkg::S_IDLE;
                        oe_nxt = 1'b0;
                    end
                    else if (etu_done)
                    begin
                        etu_nxt = '0;
                        if (bit_r == 4'(smdp_pkg::CHAR_LAST_BIT))
                        begin
                            bit_nxt = 4'h0;
                            if (byte_r == 3'(smdp_pkg::ATR_BYTES - 1))
                            begin
                                state_nxt = smdp_pkg::S_IDLE;
                                oe_nxt = 1'b0;
                            end
                            else
                            begin
                                byte_nxt = byte_r + 3'h1;
                                oe_nxt = 1'b1;
                            end
                        end
                        else
                        begin
                            bit_nxt = bit_r + 4'h1;
                            oe_nxt = !char_bit(atr_byte(ATR_DATA, byte_r), bit_r + 4'h1);
                        end
                    end
                    else if (scl_rise)
                        etu_nxt = etu_r + 1'b1;
                end
                default:
                    state_nxt = smdp_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            rst_d_r <= 1'b1;
            state_r <= smdp_pkg::S_IDLE;
            cnt_r <= 4'h0;
            sh_r <= smdp_pkg::RESET_BYTE;
            tx_r <= smdp_pkg::RESET_BYTE;
            oe_r <= 1'b0;
            ack_on_r <= 1'b0;
            ack_ok_r <= 1'b0;
            rw_r <= 1'b0;
            more_r <= 1'b0;
            page_r <= 8'h00;
            rx_r <= smdp_pkg::RESET_BYTE;
            rxv_r <= 1'b0;
            rxa_r <= 1'b0;
            txq_r <= 1'b0;
            prog_r <= 1'b0;
            busy_r <= '0;
            byte_r <= 3'h0;
            bit_r <= 4'h0;
            etu_r <= '0;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            rst_d_r <= rst_s;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            ack_on_r <= ack_on_nxt;
            ack_ok_r <= ack_ok_nxt;
            rw_r <= rw_nxt;
            more_r <= more_nxt;
            page_r <= page_nxt;
            rx_r <= rx_nxt;
            rxv_r <= rxv_nxt;
            rxa_r <= rxa_nxt;
            txq_r <= txq_nxt;
            prog_r <= prog_nxt;
            busy_r <= busy_nxt;
            byte_r <= byte_nxt;
            bit_r <= bit_nxt;
            etu_r <= etu_nxt;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = oe_r;
    assign RST_PULLUP_EN = 1'b1;
    assign TX_REQ = txq_r;
    assign RX_DATA = rx_r;
    assign RX_VALID = rxv_r;
    assign RX_ADDR = rxa_r;
    assign PROG_START = prog_r;
    assign WR_BUSY = (busy_r != '0);
    assign ATR_ACTIVE = (state_r == smdp_pkg::S_ATR);

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    chk_drive_low_only: assert property (SDA_OE |-> SDA_OUT == 1'b0) else $error("data line driven high");
    chk_sync_fall_change: assert property ((!async_s && !$past(async_s) && $changed(oe_r))
        |-> ($past(scl_fall) || $past(start_c) || $past(stop_c) || $past(state_r) == smdp_pkg::S_IDLE))
        else $error("sync output changed away from clock fall");
    // a fresh answer clears a bit count left by an aborted one, so only steps inside one answer count
    chk_etu_step: assert property ((state_r == smdp_pkg::S_ATR && $past(state_r) == smdp_pkg::S_ATR
        && $changed(bit_r) && state_nxt == state_r) |-> $past(etu_r) + 1'b1 >= $past(ETU_DIV))
        else $error("bit advanced before one etu");
    chk_atr_begin: assert property ((state_r == smdp_pkg::S_IDLE && async_s && rst_rise && !start_c)
        |=> state_r == smdp_pkg::S_ATR && oe_r) else $error("answer-to-reset not started");
    chk_no_sync_atr: assert property (state_r == smdp_pkg::S_ATR |-> $past(async_s))
        else $error("answer-to-reset in sync mode");
    chk_addr_match: assert property ($rose(state_r == smdp_pkg::S_ADDR_ACK)
        |-> rx_r[7:4] == DEV_ADDR && !WR_BUSY) else $error("acknowledged foreign address or while busy");
    chk_page_limit: assert property (page_r <= 8'(smdp_pkg::PAGE_MAX)) else $error("page over limit");
    chk_busy_after_stop: assert property (PROG_START |-> busy_r == BW'(TWR_CYCLES))
        else $error("programming time not loaded");
    chk_start_cond: assert property (start_c |=> state_r == smdp_pkg::S_ADDR && !oe_r && cnt_r == 4'h0)
        else $error("start not honoured");
    chk_ack_ninth: assert property ((state_r == smdp_pkg::S_ADDR_ACK && scl_fall && !ack_on_r
        && !start_c && !stop_c) |=> SDA_OE ##0 ack_on_r) else $error("address not acknowledged");

    cov_atr_done: cover property (state_r == smdp_pkg::S_ATR && state_nxt == smdp_pkg::S_IDLE && rst_s);
    cov_write_byte: cover property (state_r == smdp_pkg::S_WACK && SDA_OE);
    cov_read_byte: cover property (TX_REQ ##[1:1000] state_r == smdp_pkg::S_RACK);
    cov_program: cover property (PROG_START);
endmodule

//--- tb/smdp_host.sv
// far-side model: 2-wire host controller and card reader on the shared pins
`timescale 1ns/100ps
module smdp_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull_low,
    output logic rst_pin
);
    initial
    begin
        scl = 1'b1;
        pull_low = 1'b0;
        rst_pin = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // every task starts just after a rising clock edge
    task automatic pins(input logic s, input logic r);
        scl <= s;
        rst_pin <= r;
        tick(1);
    endtask

    task automatic start_c();
        pull_low <= 1'b0;
        scl <= 1'b1;
        tick(8);
        pull_low <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic stop_c();
        pull_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        pull_low <= 1'b0;
        tick(8);
    endtask

    // phases of 4 cycles: the slave answers only 3..4 cycles after a fall
    task automatic bit_io(input logic b, output logic r);
        pull_low <= !b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(!ack_in, ack);
    endtask

    // carrier periods of 160 ns, started from a parked low clock
    task automatic carrier(input int n);
        repeat (n)
        begin
            scl <= 1'b1;
            tick(4);
            scl <= 1'b0;
            tick(4);
        end
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the dual serial port front end
`timescale 1ns/100ps
module tb_top;
    localparam int TWR = 400;
    logic CLOCK, RSTN, ASYNC_MODE, SCL_CLK, RST_IN, HOST_LOW, SDA_WIRE;
    logic SDA_OUT, SDA_OE, RST_PULLUP_EN, TX_REQ, RX_VALID, RX_ADDR, PROG_START, WR_BUSY, ATR_ACTIVE;
    logic [smdp_pkg::DEV_ADDR_W-1:0] DEV_ADDR;
    logic [smdp_pkg::ETU_W-1:0] ETU_DIV;
    logic [63:0] ATR_DATA;
    logic [7:0] TX_DATA, RX_DATA;
    int failures = 0;
    int n_tests = 0;
    int n_prog = 0;
    int n_txreq = 0;
    int n_rxv = 0;

    assign SDA_WIRE = (SDA_OE ? SDA_OUT : 1'b1) & !HOST_LOW;

    smdp_port #(.TWR_CYCLES(TWR)) dut_u (.CLOCK(CLOCK), .RSTN(RSTN), .ASYNC_MODE(ASYNC_MODE), .SCL_CLK(SCL_CLK),
        .SDA_IN(SDA_WIRE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RST_IN(RST_IN), .RST_PULLUP_EN(RST_PULLUP_EN),
        .DEV_ADDR(DEV_ADDR), .ATR_DATA(ATR_DATA), .ETU_DIV(ETU_DIV), .TX_DATA(TX_DATA), .TX_REQ(TX_REQ),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_ADDR(RX_ADDR), .PROG_START(PROG_START), .WR_BUSY(WR_BUSY),
        .ATR_ACTIVE(ATR_ACTIVE));
    smdp_host host_u (.clk(CLOCK), .sda(SDA_WIRE), .scl(SCL_CLK), .pull_low(HOST_LOW), .rst_pin(RST_IN));

    initial
    begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end

    // next read byte is the inverse, so a stale byte shows up
    always @(posedge CLOCK)
    begin
        if (PROG_START === 1'b1)
            n_prog <= n_prog + 1;
        if (RX_VALID === 1'b1)
            n_rxv <= n_rxv + 1;
        if (!RSTN)
            TX_DATA <= 8'hA5;
        else if (TX_REQ === 1'b1)
        begin
            n_txreq <= n_txreq + 1;
            TX_DATA <= ~TX_DATA;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic t_reset();
        chk("data pin level", 0, SDA_OUT);
        chk("data pin drive", 0, SDA_OE);
        chk("reset pull-up", 1, RST_PULLUP_EN);
        chk("idle flags", 0, {WR_BUSY, ATR_ACTIVE, RX_DATA});
    endtask

    task automatic t_write();
        logic [7:0] rx;
        logic ack;
        host_u.start_c();
        host_u.byte_io(8'h50, 1'b0, rx, ack);
        chk("address ack", 0, ack);
        chk("address byte", 9'h150, {RX_ADDR, RX_DATA});
        host_u.byte_io(8'h3C, 1'b0, rx, ack);
        chk("data ack", 0, ack);
        chk("data byte", 9'h03C, {RX_ADDR, RX_DATA});
        host_u.stop_c();
        chk("rx pulses", 2, n_rxv);
        chk("program pulse", 1, n_prog);
        chk("busy after stop", 1, WR_BUSY);
        host_u.start_c();
        host_u.byte_io(8'h50, 1'b0, rx, ack);
        chk("busy refuses", 1, ack);
        host_u.stop_c();
        tick(TWR);
        chk("busy ends", 0, WR_BUSY);
    endtask

    task automatic t_page();
        logic [7:0] rx;
        logic ack;
        int nacks;
        nacks = 0;
        host_u.start_c();
        host_u.byte_io(8'h5E, 1'b0, rx, ack);
        for (int i = 0; i < 128; i++)
        begin
            host_u.byte_io(8'(i), 1'b0, rx, ack);
            if (ack !== 1'b0)
                nacks++;
        end
        chk("page acks", 0, nacks);
        host_u.byte_io(8'hEE, 1'b0, rx, ack);
        chk("byte past page", 1, ack);
        host_u.stop_c();
        chk("page program", 2, n_prog);
        tick(TWR);
    endtask

    task automatic t_foreign();
        logic [7:0] rx;
        logic ack;
        host_u.start_c();
        host_u.byte_io(8'h70, 1'b0, rx, ack);
        chk("foreign no ack", 1, ack);
        chk("foreign byte", 9'h170, {RX_ADDR, RX_DATA});
        host_u.stop_c();
    endtask

    task automatic t_read();
        logic [7:0] rx;
        logic ack;
        host_u.start_c();
        host_u.byte_io(8'h51, 1'b0, rx, ack);
        chk("read address ack", 0, ack);
        host_u.byte_io(8'hFF, 1'b1, rx, ack);
        chk("read byte one", 8'hA5, rx);
        host_u.byte_io(8'hFF, 1'b0, rx, ack);
        chk("read byte two", 8'h5A, rx);
        host_u.stop_c();
        chk("read loads", 2, n_txreq);
    endtask

    task automatic t_sync_rst();
        host_u.pins(1'b1, 1'b0);
        tick(8);
        host_u.pins(1'b1, 1'b1);
        tick(8);
        chk("no sync answer", 0, {ATR_ACTIVE, SDA_OE});
    endtask

    task automatic t_etu();
        int cnt;
        ASYNC_MODE <= 1'b1;
        host_u.pins(1'b0, 1'b0);
        tick(8);
        host_u.pins(1'b0, 1'b1);
        tick(6);
        chk("answer starts", 2'h3, {ATR_ACTIVE, SDA_OE});
        cnt = 0;
        for (int i = 0; i < 380; i++)
        begin
            host_u.carrier(1);
            if (SDA_OE === 1'b1)
                cnt++;
        end
        chk("start bit length", smdp_pkg::ETU_DEFAULT - 1, cnt);
        host_u.pins(1'b0, 1'b0);
        tick(6);
        chk("abort releases", 0, {ATR_ACTIVE, SDA_OE});
    endtask

    task automatic t_atr();
        logic [95:0] seen;
        logic [11:0] exp;
        ETU_DIV <= 9'h004;
        tick(4);
        host_u.pins(1'b0, 1'b1);
        tick(6);
        chk("fast answer starts", 1, ATR_ACTIVE);
        for (int i = 0; i < 96; i++)
        begin
            host_u.carrier(i == 0 ? 2 : 4);
            seen[i] = SDA_WIRE;
        end
        for (int i = 0; i < 8; i++)
        begin
            exp = {2'b11, ^ATR_DATA[8*i +: 8], ATR_DATA[8*i +: 8], 1'b0};
            chk("answer character", exp, seen[12*i +: 12]);
        end
        host_u.carrier(4);
        tick(4);
        chk("answer ends", 0, ATR_ACTIVE);
    endtask

    initial
    begin
        RSTN = 1'b0;
        ASYNC_MODE = 1'b0;
        DEV_ADDR = 4'h5;
        ETU_DIV = 9'h174;
        ATR_DATA = 64'h8C3A51E70F96D42B;
        // two reset edges preload both synchroniser flops
        tick(2);
        RSTN <= 1'b1;
        tick(2);
        t_reset();
        tick(4);
        t_write();
        t_page();
        t_foreign();
        t_read();
        t_sync_rst();
        t_etu();
        t_atr();
        close_out();
    end

    initial
    begin
        // all scenarios together take about 27000 cycles
        tick(40000);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        close_out();
    end
endmodule
